//--- tb/sdram_cmd_model.sv
`default_nettype none
module sdram_cmd_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sdram command pins
    input wire logic [2:0] sdram_cmd,
    input wire logic [15:0] sdram_addr,
    // observed sequence
    output logic [15:0] mode_q,
    output logic [7:0] mrs_cnt_q,
    output logic [3:0] ref_cnt_q,
    output logic [7:0] pre_gap_q,
    output logic [7:0] ref_gap_q,
    output logic order_bad_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle_q;
    logic in_seq_q;
    ////////////////////////////////////////////////////////////////////////
    // the model latches the mode on any MRS, even outside the full precharge/refresh run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 16'h0000;
            mrs_cnt_q <= 8'h00;
            ref_cnt_q <= 4'h0;
            pre_gap_q <= 8'h00;
            ref_gap_q <= 8'h00;
            order_bad_q <= 1'b0;
            idle_q <= 8'h00;
            in_seq_q <= 1'b0;
        end else begin
            idle_q <= idle_q + 8'h01;
            case (sdram_cmd)
                sdram_mode_pkg::CMD_PALL: begin
                    ref_cnt_q <= 4'h0;
                    idle_q <= 8'h00;
                    in_seq_q <= 1'b1;
                end
                sdram_mode_pkg::CMD_REF: begin
                    if (!in_seq_q || ref_cnt_q == 4'h8) order_bad_q <= 1'b1;
                    if (ref_cnt_q == 4'h0) pre_gap_q <= idle_q;
                    else ref_gap_q <= idle_q;
                    if (ref_cnt_q > 4'h1 && idle_q != ref_gap_q) order_bad_q <= 1'b1;
                    ref_cnt_q <= ref_cnt_q + 4'h1;
                    idle_q <= 8'h00;
                end
                sdram_mode_pkg::CMD_MRS: begin
                    if (!in_seq_q || ref_cnt_q != 4'h8) order_bad_q <= 1'b1;
                    if (idle_q != ref_gap_q) order_bad_q <= 1'b1;
                    mode_q <= sdram_addr;
                    mrs_cnt_q <= mrs_cnt_q + 8'h01;
                    in_seq_q <= 1'b0;
                end
                sdram_mode_pkg::CMD_NOP: ;
                default: order_bad_q <= 1'b1;
            endcase
        end
    end
endmodule : sdram_cmd_model
`default_nettype wire

//--- tb/sdram_mode_register_setup_tb.sv
`default_nettype none
module sdram_mode_register_setup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_busy, rd_wr_n;
    logic area3_sel, cyc_active, cyc_write, read_timing, write_timing, err, order_bad_q;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [2:0] sdram_cmd;
    logic [15:0] sdram_addr, mode_q;
    logic [3:0] byte_en, byte_write_strobe_n, ref_cnt_q;
    logic [7:0] mrs_cnt_q, pre_gap_q, ref_gap_q;
    int num_errors, n_checks;
    logic [31:0] trig [8] = '{sdram_mode_pkg::TRIG_SW_N_CL2, sdram_mode_pkg::TRIG_SW_N_CL3,
        sdram_mode_pkg::TRIG_SW_W_CL2, sdram_mode_pkg::TRIG_SW_W_CL3,
        sdram_mode_pkg::TRIG_BW_N_CL2, sdram_mode_pkg::TRIG_BW_N_CL3,
        sdram_mode_pkg::TRIG_BW_W_CL2, sdram_mode_pkg::TRIG_BW_W_CL3};
    // pin values worked out by hand from the field placement per bus width
    logic [15:0] pin [8] = '{16'h0440, 16'h0460, 16'h0880, 16'h08C0,
        16'h0040, 16'h0060, 16'h0080, 16'h00C0};
    // {area3_sel, cyc_active, read_timing, write_timing}, strobes, direction
    logic [3:0] ctl [5] = '{4'h5, 4'h6, 4'hC, 4'hD, 4'h8};
    logic [4:0] bexp [5] = '{5'h1E, 5'h14, 5'h15, 5'h14, 5'h1F};
    ////////////////////////////////////////////////////////////////////////
    sdram_mode_register_setup u_sdram_mode_register_setup (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sdram_cmd(sdram_cmd), .sdram_addr(sdram_addr), .seq_busy(seq_busy),
        .area3_sel(area3_sel), .cyc_active(cyc_active), .cyc_write(cyc_write),
        .byte_en(byte_en), .read_timing(read_timing), .write_timing(write_timing),
        .byte_write_strobe_n(byte_write_strobe_n), .rd_wr_n(rd_wr_n));
    sdram_cmd_model u_sdram_cmd_model (
        .pclk(pclk), .presetn(presetn), .sdram_cmd(sdram_cmd), .sdram_addr(sdram_addr),
        .mode_q(mode_q), .mrs_cnt_q(mrs_cnt_q), .ref_cnt_q(ref_cnt_q),
        .pre_gap_q(pre_gap_q), .ref_gap_q(ref_gap_q), .order_bad_q(order_bad_q));
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            num_errors++;
        end
    endtask : check
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 500) begin
            num_errors++;
            wrap_up();
        end
    endtask : apb
    task automatic wait_mrs(input logic [7:0] k);
        int n;
        n = 0;
        while (mrs_cnt_q !== k && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            wrap_up();
        end
    endtask : wait_mrs
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, area3_sel, cyc_active, cyc_write} = 7'h00;
        {read_timing, write_timing} = 2'h0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        byte_en = 4'h5;
        num_errors = 0;
        n_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, sdram_mode_pkg::AREA2_WAIT_ADDR, 32'h00000000);
        check(rd, sdram_mode_pkg::WAIT_RESET);
        apb(1'b0, sdram_mode_pkg::AREA3_WAIT_ADDR, 32'h00000000);
        check(rd, sdram_mode_pkg::WAIT_RESET);
        // all ones on purpose: reserved bits must still read back zero
        apb(1'b1, sdram_mode_pkg::AREA2_WAIT_ADDR, 32'hFFFFFFFF);
        apb(1'b0, sdram_mode_pkg::AREA2_WAIT_ADDR, 32'h00000000);
        check(rd, sdram_mode_pkg::WAIT_MASK);
        apb(1'b1, sdram_mode_pkg::AREA3_WAIT_ADDR, 32'hFFFFFFFF);
        apb(1'b0, sdram_mode_pkg::AREA3_WAIT_ADDR, 32'h00000000);
        check(rd, sdram_mode_pkg::WAIT_MASK | sdram_mode_pkg::AREA3_EXTRA_MASK);
        apb(1'b0, 32'hFFFC0010, 32'h00000000);
        check({rd[30:0], err}, 32'h00000001);
        // strobe timing: area2 select clear, area3 select set
        // reserved bits written zero
        apb(1'b1, sdram_mode_pkg::AREA2_WAIT_ADDR, 32'h00000000);
        apb(1'b1, sdram_mode_pkg::AREA3_WAIT_ADDR, 32'h00100000);
        cyc_write <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            @(posedge pclk);
            {area3_sel, cyc_active, read_timing, write_timing} <= ctl[i];
            @(posedge pclk);
            #1;
            check({27'h0, byte_write_strobe_n, rd_wr_n}, {27'h0, bexp[i]});
        end
        // every trigger address, with idle fields varied per pass
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, sdram_mode_pkg::AREA3_WAIT_ADDR, 32'((i % 4) << 3) | 32'(3 - i % 4));
            apb(1'b1, trig[i], 32'h00000000);
            #1;
            check({31'h0, seq_busy}, 32'h00000001);
            wait_mrs(8'(i + 1));
            repeat (2) @(posedge pclk);
            #1;
            check({16'h0, mode_q}, {16'h0, pin[i]});
            check({28'h0, ref_cnt_q}, 32'h00000008);
            check({24'h0, pre_gap_q}, 32'(i % 4));
            check({24'h0, ref_gap_q}, 32'(3 - i % 4));
            check({31'h0, order_bad_q}, 32'h00000000);
            check({31'h0, seq_busy}, 32'h00000000);
        end
        // second trigger lands while busy and must stall until the run ends
        apb(1'b1, trig[0], 32'h00000000);
        apb(1'b1, trig[3], 32'h00000000);
        check({24'h0, mrs_cnt_q}, 32'h00000009);
        wait_mrs(8'h0A);
        repeat (2) @(posedge pclk);
        #1;
        check({16'h0, mode_q}, {16'h0, pin[3]});
        check({31'h0, order_bad_q}, 32'h00000000);
        // status after a finished run: idle, refresh count at eight, not busy
        apb(1'b0, sdram_mode_pkg::STATUS_ADDR, 32'h00000000);
        check(rd, 32'h00000020);
        wrap_up();
    end
endmodule : sdram_mode_register_setup_tb
`default_nettype wire

//--- verilog/byte_strobe_timing.sv
`default_nettype none
module byte_strobe_timing (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic byte_access_select,
    // access cycle
    input wire logic cyc_active,
    input wire logic cyc_write,
    input wire logic [3:0] byte_en,
    input wire logic read_timing,
    input wire logic write_timing,
    // sram pins
    output logic [3:0] byte_write_strobe_n,
    output logic rd_wr_n
);
    logic [3:0] strobe_d;
    logic dir_d;

    always_comb begin
        if (byte_access_select) begin
            // [R2] strobes whole cycle
            strobe_d = cyc_active ? ~byte_en : 4'hF;
            dir_d = ~(cyc_active & cyc_write & write_timing);
        end else begin
            // [R1] strobes at read timing
            strobe_d = (cyc_active & read_timing) ? ~byte_en : 4'hF;
            dir_d = ~(cyc_active & cyc_write);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_write_strobe_n <= 4'hF;
            rd_wr_n <= 1'b1;
        end else begin
            byte_write_strobe_n <= strobe_d;
            rd_wr_n <= dir_d;
        end
    end

    a_strobe_rd_time: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        !byte_access_select && cyc_active && !read_timing |=> byte_write_strobe_n == 4'hF)
        else $error("strobe outside read timing");
    a_dir_whole_cyc: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        !byte_access_select && cyc_active && cyc_write |=> !rd_wr_n)
        else $error("direction not asserted in write cycle");
    a_strobe_cycle: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        byte_access_select && cyc_active |=> byte_write_strobe_n == ~$past(byte_en))
        else $error("strobe missing in access cycle");
    a_dir_wr_time: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        byte_access_select && !write_timing |=> rd_wr_n)
        else $error("direction outside write timing");
endmodule : byte_strobe_timing
`default_nettype wire

//--- verilog/sdram_mode_pkg.sv
`default_nettype none
package sdram_mode_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [31:0] AREA2_WAIT_ADDR = 32'hFFFC0000;
    localparam logic [31:0] AREA3_WAIT_ADDR = 32'hFFFC0004;
    localparam logic [31:0] STATUS_ADDR = 32'hFFFC0008;
    localparam logic [31:0] WAIT_RESET = 32'h00000500;
    localparam logic [31:0] WAIT_MASK = 32'h001007C0;
    localparam logic [31:0] AREA3_EXTRA_MASK = 32'h0000001B;
    localparam int BYTE_SEL_BIT = 20;
    localparam int PRE_IDLE_LSB = 3;
    localparam int REF_IDLE_LSB = 0;
    ////////////////////////////////////////////////////////////////////////
    // mode register trigger addresses
    localparam logic [31:0] TRIG_SW_N_CL2 = 32'hFFFC5440;
    localparam logic [31:0] TRIG_SW_N_CL3 = 32'hFFFC5460;
    localparam logic [31:0] TRIG_SW_W_CL2 = 32'hFFFC5880;
    localparam logic [31:0] TRIG_SW_W_CL3 = 32'hFFFC58C0;
    localparam logic [31:0] TRIG_BW_N_CL2 = 32'hFFFC5040;
    localparam logic [31:0] TRIG_BW_N_CL3 = 32'hFFFC5060;
    localparam logic [31:0] TRIG_BW_W_CL2 = 32'hFFFC5080;
    localparam logic [31:0] TRIG_BW_W_CL3 = 32'hFFFC50C0;
    ////////////////////////////////////////////////////////////////////////
    // mode value fields
    localparam logic [6:0] WBM_BURST = 7'h00;
    localparam logic [6:0] WBM_SINGLE = 7'h04;
    localparam logic [2:0] CL_TWO = 3'h2;
    localparam logic [2:0] CL_THREE = 3'h3;
    localparam logic WRAP_SEQ = 1'b0;
    localparam logic [2:0] BL_ONE = 3'h0;
    localparam int WIDE_SHIFT = 2;
    localparam int NARROW_SHIFT = 1;
    localparam logic [3:0] REF_TOTAL = 4'h8;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_PALL = 3'h1,
        CMD_REF = 3'h2,
        CMD_MRS = 3'h3
    } sdram_cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PALL = 3'h1,
        ST_PRE_GAP = 3'h3,
        ST_REF = 3'h2,
        ST_REF_GAP = 3'h6,
        ST_MRS = 3'h7
    } seq_state_e;

    // mode value as it leaves on the address pins
    function automatic logic [15:0] mode_pins(input logic single, input logic cl3,
                                              input logic wide);
        logic [13:0] m;
        m = {single ? WBM_SINGLE : WBM_BURST, cl3 ? CL_THREE : CL_TWO, WRAP_SEQ, BL_ONE};
        return wide ? (16'(m) << WIDE_SHIFT) : (16'(m) << NARROW_SHIFT);
    endfunction : mode_pins
endpackage : sdram_mode_pkg
`default_nettype wire

//--- verilog/sdram_mode_register_setup.sv
// The address map and register access over APB are this design's own decisions.
`default_nettype none
// Overview of operation
// [R1] byte select 0: strobes at read timing
// [R2] byte select 1: strobes whole cycle, direction at write
// [R3] reserved wait bits read zero
// [R4] software writes zero to reserved bits
// [R5] single-write trigger address starts mode write
// [R6] burst-write trigger address starts mode write
// [R7] write-burst field zero or single-write value
// [R8] cas field 010 or 011
// [R9] wrap bit zero, sequential
// [R10] burst length field 000
// [R11] 32-bit bus pin placement
// [R12] 16-bit bus pin placement
// [R13] precharge-all comes first
// [R14] exactly eight auto-refreshes follow
// [R15] mode write issued last
// [R16] precharge idle cycles from area 3 field
// [R17] refresh idle cycles after each refresh
module sdram_mode_register_setup (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sdram command pins
    output logic [2:0] sdram_cmd,
    output logic [15:0] sdram_addr,
    output logic seq_busy,
    // byte-selection sram access
    input wire logic area3_sel,
    input wire logic cyc_active,
    input wire logic cyc_write,
    input wire logic [3:0] byte_en,
    input wire logic read_timing,
    input wire logic write_timing,
    output logic [3:0] byte_write_strobe_n,
    output logic rd_wr_n
);
    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic [31:0] area2_wait_control_q;
    logic [31:0] area3_wait_control_q;
    sdram_mode_pkg::seq_state_e state_q, state_d;
    logic [1:0] gap_q, gap_d;
    logic [3:0] ref_q, ref_d;
    logic single_q, cl3_q, wide_q;
    logic access, trig_hit, trig_single, trig_cl3, trig_wide, reg_hit, trig_fire;
    logic [1:0] pre_idle, ref_idle;

    assign access = psel & penable;

    always_comb begin
        trig_hit = 1'b1;
        trig_single = 1'b0;
        trig_cl3 = 1'b0;
        trig_wide = 1'b0;
        unique case (paddr)
            sdram_mode_pkg::TRIG_SW_N_CL2: trig_single = 1'b1;
            sdram_mode_pkg::TRIG_SW_N_CL3: {trig_single, trig_cl3} = 2'h3;
            sdram_mode_pkg::TRIG_SW_W_CL2: {trig_single, trig_wide} = 2'h3;
            sdram_mode_pkg::TRIG_SW_W_CL3: {trig_single, trig_cl3, trig_wide} = 3'h7;
            sdram_mode_pkg::TRIG_BW_N_CL2: trig_hit = 1'b1;
            sdram_mode_pkg::TRIG_BW_N_CL3: trig_cl3 = 1'b1;
            sdram_mode_pkg::TRIG_BW_W_CL2: trig_wide = 1'b1;
            sdram_mode_pkg::TRIG_BW_W_CL3: {trig_cl3, trig_wide} = 2'h3;
            default: trig_hit = 1'b0;
        endcase
    end

    assign reg_hit = (paddr == sdram_mode_pkg::AREA2_WAIT_ADDR) |
                     (paddr == sdram_mode_pkg::AREA3_WAIT_ADDR) |
                     (paddr == sdram_mode_pkg::STATUS_ADDR);
    // a trigger write while a sequence runs waits rather than being lost
    assign pready = ~(access & pwrite & trig_hit & seq_busy);
    assign pslverr = access & ~reg_hit & ~trig_hit;
    // [R5] [R6] trigger on address write
    assign trig_fire = access & pwrite & trig_hit & pready;

    ////////////////////////////////////////////////////////////////////////
    // wait control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            area2_wait_control_q <= sdram_mode_pkg::WAIT_RESET;
            area3_wait_control_q <= sdram_mode_pkg::WAIT_RESET;
        end else if (access & pwrite & pready) begin
            // [R3] reserved bits never stored
            if (paddr == sdram_mode_pkg::AREA2_WAIT_ADDR) begin
                area2_wait_control_q <= pwdata & sdram_mode_pkg::WAIT_MASK;
            end
            if (paddr == sdram_mode_pkg::AREA3_WAIT_ADDR) begin
                area3_wait_control_q <= pwdata &
                    (sdram_mode_pkg::WAIT_MASK | sdram_mode_pkg::AREA3_EXTRA_MASK);
            end
        end
    end

    always_comb begin
        prdata = 32'h00000000;
        if (access & ~pwrite) begin
            if (paddr == sdram_mode_pkg::AREA2_WAIT_ADDR) begin
                prdata = area2_wait_control_q;
            end else if (paddr == sdram_mode_pkg::AREA3_WAIT_ADDR) begin
                prdata = area3_wait_control_q;
            end else if (paddr == sdram_mode_pkg::STATUS_ADDR) begin
                prdata = {23'h000000, state_q, ref_q, seq_busy, 1'b0};
            end
        end
    end

    assign pre_idle = area3_wait_control_q[sdram_mode_pkg::PRE_IDLE_LSB +: 2];
    assign ref_idle = area3_wait_control_q[sdram_mode_pkg::REF_IDLE_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // mode setting sequence
    always_comb begin
        state_d = state_q;
        gap_d = gap_q;
        ref_d = ref_q;
        unique case (state_q)
            sdram_mode_pkg::ST_IDLE: begin
                // [R13] precharge-all first
                if (trig_fire) begin
                    state_d = sdram_mode_pkg::ST_PALL;
                end
            end
            sdram_mode_pkg::ST_PALL: begin
                ref_d = 4'h0;
                // [R16] precharge idle gap
                if (pre_idle == 2'h0) begin
                    state_d = sdram_mode_pkg::ST_REF;
                end else begin
                    state_d = sdram_mode_pkg::ST_PRE_GAP;
                    gap_d = pre_idle - 2'h1;
                end
            end
            sdram_mode_pkg::ST_PRE_GAP: begin
                if (gap_q == 2'h0) begin
                    state_d = sdram_mode_pkg::ST_REF;
                end else begin
                    gap_d = gap_q - 2'h1;
                end
            end
            sdram_mode_pkg::ST_REF: begin
                // [R14] count eight refreshes
                ref_d = ref_q + 4'h1;
                // [R17] refresh idle gap
                if (ref_idle != 2'h0) begin
                    state_d = sdram_mode_pkg::ST_REF_GAP;
                    gap_d = ref_idle - 2'h1;
                end else if (ref_d == sdram_mode_pkg::REF_TOTAL) begin
                    state_d = sdram_mode_pkg::ST_MRS;
                end
            end
            sdram_mode_pkg::ST_REF_GAP: begin
                if (gap_q != 2'h0) begin
                    gap_d = gap_q - 2'h1;
                end else if (ref_q == sdram_mode_pkg::REF_TOTAL) begin
                    // [R15] mode write last
                    state_d = sdram_mode_pkg::ST_MRS;
                end else begin
                    state_d = sdram_mode_pkg::ST_REF;
                end
            end
            sdram_mode_pkg::ST_MRS: state_d = sdram_mode_pkg::ST_IDLE;
            default: state_d = sdram_mode_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= sdram_mode_pkg::ST_IDLE;
            gap_q <= 2'h0;
            ref_q <= 4'h0;
        end else begin
            state_q <= state_d;
            gap_q <= gap_d;
            ref_q <= ref_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_q <= 1'b0;
            cl3_q <= 1'b0;
            wide_q <= 1'b0;
        end else if (trig_fire) begin
            single_q <= trig_single;
            cl3_q <= trig_cl3;
            wide_q <= trig_wide;
        end
    end

    assign seq_busy = (state_q != sdram_mode_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // command pins, registered from the next state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdram_cmd <= sdram_mode_pkg::CMD_NOP;
            sdram_addr <= 16'h0000;
        end else begin
            sdram_addr <= 16'h0000;
            unique case (state_d)
                sdram_mode_pkg::ST_PALL: sdram_cmd <= sdram_mode_pkg::CMD_PALL;
                sdram_mode_pkg::ST_REF: sdram_cmd <= sdram_mode_pkg::CMD_REF;
                sdram_mode_pkg::ST_MRS: begin
                    sdram_cmd <= sdram_mode_pkg::CMD_MRS;
                    // [R7] [R8] [R9] [R10] [R11] [R12] mode value on pins
                    sdram_addr <= sdram_mode_pkg::mode_pins(
                        trig_fire ? trig_single : single_q,
                        trig_fire ? trig_cl3 : cl3_q,
                        trig_fire ? trig_wide : wide_q);
                end
                default: sdram_cmd <= sdram_mode_pkg::CMD_NOP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte-selection sram strobes
    byte_strobe_timing u_strobe (
        .pclk(pclk),
        .presetn(presetn),
        .byte_access_select(area3_sel ? area3_wait_control_q[sdram_mode_pkg::BYTE_SEL_BIT] :
                                        area2_wait_control_q[sdram_mode_pkg::BYTE_SEL_BIT]),
        .cyc_active(cyc_active),
        .cyc_write(cyc_write),
        .byte_en(byte_en),
        .read_timing(read_timing),
        .write_timing(write_timing),
        .byte_write_strobe_n(byte_write_strobe_n),
        .rd_wr_n(rd_wr_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // checking helpers
    logic [2:0] last_cmd_q;
    logic [2:0] nop_run_q;
    logic [3:0] refs_seen_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cmd_q <= sdram_mode_pkg::CMD_NOP;
            nop_run_q <= 3'h0;
            refs_seen_q <= 4'h0;
        end else begin
            if (sdram_cmd != sdram_mode_pkg::CMD_NOP) begin
                last_cmd_q <= sdram_cmd;
                nop_run_q <= 3'h0;
            end else if (nop_run_q != 3'h7) begin
                nop_run_q <= nop_run_q + 3'h1;
            end
            if (sdram_cmd == sdram_mode_pkg::CMD_PALL) begin
                refs_seen_q <= 4'h0;
            end else if (sdram_cmd == sdram_mode_pkg::CMD_REF) begin
                refs_seen_q <= refs_seen_q + 4'h1;
            end
        end
    end

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        access && !pwrite && pready |-> (prdata & 32'hFFEFF800) == 32'h00000000 ||
        paddr == sdram_mode_pkg::STATUS_ADDR)
        else $error("reserved wait bits read nonzero");
    a_pall_first: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        trig_fire |=> sdram_cmd == sdram_mode_pkg::CMD_PALL)
        else $error("sequence did not open with precharge-all");
    a_ref_bound: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        sdram_cmd == sdram_mode_pkg::CMD_REF |-> refs_seen_q < sdram_mode_pkg::REF_TOTAL)
        else $error("more than eight refreshes");
    a_mrs_after8: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        sdram_cmd == sdram_mode_pkg::CMD_MRS |-> refs_seen_q == sdram_mode_pkg::REF_TOTAL &&
        last_cmd_q == sdram_mode_pkg::CMD_REF)
        else $error("mode write before eight refreshes");
    a_pre_gap: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        sdram_cmd == sdram_mode_pkg::CMD_REF && last_cmd_q == sdram_mode_pkg::CMD_PALL
        |-> nop_run_q == {1'b0, pre_idle})
        else $error("wrong idle count after precharge-all");
    a_ref_gap: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        sdram_cmd != sdram_mode_pkg::CMD_NOP && last_cmd_q == sdram_mode_pkg::CMD_REF
        |-> nop_run_q == {1'b0, ref_idle})
        else $error("wrong idle count after refresh");
    a_mode_trig: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        trig_fire && paddr == sdram_mode_pkg::TRIG_SW_W_CL2
        |=> single_q && wide_q && !cl3_q)
        else $error("single-write trigger not decoded");
    a_mode_wbm: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        sdram_cmd == sdram_mode_pkg::CMD_MRS && wide_q
        |-> sdram_addr[15:9] == (single_q ? 7'h04 : 7'h00))
        else $error("write-burst field wrong");
    a_mode_cas: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        sdram_cmd == sdram_mode_pkg::CMD_MRS && !wide_q
        |-> sdram_addr[7:5] == (cl3_q ? 3'h3 : 3'h2))
        else $error("cas field wrong");
    a_pins_narrow: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        sdram_cmd == sdram_mode_pkg::CMD_MRS && !wide_q
        |-> sdram_addr[4:0] == 5'h00 && sdram_addr[15] == 1'b0)
        else $error("16-bit wrap or burst length pins wrong");
    a_pins_wide: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        sdram_cmd == sdram_mode_pkg::CMD_MRS && wide_q |-> sdram_addr[5:0] == 6'h00)
        else $error("32-bit wrap or burst length pins wrong");
endmodule : sdram_mode_register_setup
`default_nettype wire
